/* mgmt_station_model.sv */
// station management controller model driving the portal strobes
`timescale 1ns/1ps
module mgmt_station_model (
  input  wire logic        mclk_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic      [4:0]  addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [15:0] wdata_out
);
  // ==========================================================
  // idle bus
  initial begin
    addr_out  = 5'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 16'h0000;
  end

  // one write strobe; released data shows the inverse so a stale value never passes
  task automatic put(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge mclk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;
  endtask

  // one read strobe; the answer stands only in the cycle after the strobe
  task automatic get(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge mclk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge mclk_in);
    rd_out   <= 1'b0;
    #1;
    ok = rvalid_in;
    d  = rdata_in;
  endtask

  // device address with op 00, register address, then the data mode
  task automatic sel(input logic [4:0] dev, input logic [15:0] rg, input logic [1:0] op);
    put(phy_mmd_pkg::PORTAL_CTRL_REG, {phy_mmd_pkg::OP_REGISTER, 9'h000, dev});
    put(phy_mmd_pkg::PORTAL_DATA_REG, rg);
    put(phy_mmd_pkg::PORTAL_CTRL_REG, {op, 9'h000, dev});
  endtask
endmodule

/* mmd_reg16.sv */
// one masked read-write configuration register with a reset value
`timescale 1ns/1ps
module mmd_reg16 #(
  parameter int          WIDTH     = 16,
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WMASK     = 16'hFFFF
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic             we_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  output logic      [WIDTH-1:0] q_out
);
  // elaboration check: the masks and reset values are 16 bits wide
  if (WIDTH != 16) begin : g_bad_width
    $error("mmd_reg16 supports 16-bit registers only");
  end

  // masked bits keep their reset value, so read-only fields stay constant
  wire [WIDTH-1:0] next_q = (q_out & ~WMASK) | (wdata_in & WMASK);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_out <= RESET_VAL;
    end else if (ce_in && we_in) begin
      q_out <= next_q;
    end
  end
endmodule

/* phy_mmd_config.sv */
// mmd portal and indirect configuration register bank
`timescale 1ns/1ps
module phy_mmd_config #(
  parameter int DATA_W = 16
) (
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  input  wire logic [4:0]        mgmt_addr_in,
  input  wire logic              mgmt_wr_in,
  input  wire logic              mgmt_rd_in,
  input  wire logic [DATA_W-1:0] mgmt_wdata_in,
  input  wire logic              indicator_style_strap_in,
  output logic      [DATA_W-1:0] mgmt_rdata_out,
  output logic                   mgmt_rvalid_out,
  output logic      [DATA_W-1:0] flp_low_out,
  output logic      [DATA_W-1:0] flp_high_out,
  output logic      [2:0]        link_up_time_out,
  output logic                   indicator_style_out
);
  // elaboration check: the portal and every indirect register are 16 bits
  if (DATA_W != 16) begin : g_bad_width
    $error("phy_mmd_config needs 16-bit management data");
  end

  // ==========================================================
  // portal decode
  logic [15:0] portal_ctrl;
  logic [15:0] mmd_addr;
  logic [15:0] link_up_q;
  logic [15:0] common_q;
  logic        strap_taken;

  wire [1:0]  op        = portal_ctrl[phy_mmd_pkg::CTRL_OP_MSB:phy_mmd_pkg::CTRL_OP_LSB];
  wire [4:0]  dev       = portal_ctrl[phy_mmd_pkg::CTRL_DEV_MSB:0];
  wire        data_mode = (op != phy_mmd_pkg::OP_REGISTER);
  wire        wr_ctrl   = ce_in && mgmt_wr_in && (mgmt_addr_in == phy_mmd_pkg::PORTAL_CTRL_REG);
  wire        wr_data   = ce_in && mgmt_wr_in && (mgmt_addr_in == phy_mmd_pkg::PORTAL_DATA_REG);
  wire        rd_any    = ce_in && mgmt_rd_in;
  wire        rd_data   = rd_any && (mgmt_addr_in == phy_mmd_pkg::PORTAL_DATA_REG);
  wire        mmd_wr    = wr_data && data_mode;
  wire        mmd_rd    = rd_data && data_mode;

  // which indirect register the portal points at
  wire sel_flp_lo = (dev == phy_mmd_pkg::DEV_AUTONEG) && (mmd_addr == phy_mmd_pkg::FLP_LOW_ADDR);
  wire sel_flp_hi = (dev == phy_mmd_pkg::DEV_AUTONEG) && (mmd_addr == phy_mmd_pkg::FLP_HIGH_ADDR);
  wire sel_link   = (dev == phy_mmd_pkg::DEV_PMA) && (mmd_addr == phy_mmd_pkg::LINK_UP_ADDR);
  wire sel_common = (dev == phy_mmd_pkg::DEV_COMMON) && (mmd_addr == phy_mmd_pkg::COMMON_ADDR);

  // post increment per operation code
  wire inc_rw   = (op == phy_mmd_pkg::OP_DATA_INC_RW) && (mmd_wr || mmd_rd);
  wire inc_wr   = (op == phy_mmd_pkg::OP_DATA_INC_WR) && mmd_wr;
  wire addr_set = wr_data && !data_mode;
  wire [15:0] next_mmd_addr = addr_set ? mgmt_wdata_in
                            : (inc_rw || inc_wr) ? mmd_addr + phy_mmd_pkg::ADDR_STEP
                            : mmd_addr;

  // ==========================================================
  // read path; override bit always reads back zero
  wire [15:0] common_view = {common_q[15:phy_mmd_pkg::OVERRIDE_BIT+1], 1'b0,
                             indicator_style_out, common_q[phy_mmd_pkg::STYLE_BIT-1:0]};
  wire [15:0] mmd_view = sel_flp_lo ? flp_low_out
                       : sel_flp_hi ? flp_high_out
                       : sel_link   ? link_up_q
                       : sel_common ? common_view
                       : phy_mmd_pkg::READ_NONE; // unmapped indirect registers read zero
  wire [15:0] next_rdata = (mgmt_addr_in == phy_mmd_pkg::PORTAL_CTRL_REG) ? portal_ctrl
                         : (mgmt_addr_in == phy_mmd_pkg::PORTAL_DATA_REG)
                           ? (data_mode ? mmd_view : mmd_addr)
                           : phy_mmd_pkg::READ_NONE;

  // ==========================================================
  // register instances
  mmd_reg16 #(.WIDTH(16), .RESET_VAL(phy_mmd_pkg::CTRL_RESET), .WMASK(phy_mmd_pkg::ALL_WRITABLE)) u_ctrl (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .we_in    (wr_ctrl),
    .wdata_in (mgmt_wdata_in),
    .q_out    (portal_ctrl)
  );

  mmd_reg16 #(.WIDTH(16), .RESET_VAL(phy_mmd_pkg::FLP_LOW_RESET), .WMASK(phy_mmd_pkg::ALL_WRITABLE)) u_flp_lo (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .we_in    (mmd_wr && sel_flp_lo),
    .wdata_in (mgmt_wdata_in),
    .q_out    (flp_low_out)
  );

  mmd_reg16 #(.WIDTH(16), .RESET_VAL(phy_mmd_pkg::FLP_HIGH_RESET), .WMASK(phy_mmd_pkg::ALL_WRITABLE)) u_flp_hi (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .we_in    (mmd_wr && sel_flp_hi),
    .wdata_in (mgmt_wdata_in),
    .q_out    (flp_high_out)
  );

  // upper bits masked so they stay zero
  mmd_reg16 #(.WIDTH(16), .RESET_VAL(phy_mmd_pkg::LINK_UP_RESET), .WMASK(phy_mmd_pkg::LINK_UP_WMASK)) u_link (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .we_in    (mmd_wr && sel_link),
    .wdata_in (mgmt_wdata_in),
    .q_out    (link_up_q)
  );

  // style bits live outside this register, hence masked off
  mmd_reg16 #(.WIDTH(16), .RESET_VAL(phy_mmd_pkg::COMMON_RESET), .WMASK(phy_mmd_pkg::COMMON_WMASK)) u_common (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .we_in    (mmd_wr && sel_common),
    .wdata_in (mgmt_wdata_in),
    .q_out    (common_q)
  );

  // ==========================================================
  // portal address, strap capture, read answer
  // strap is caught after release, never loaded asynchronously
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mmd_addr            <= phy_mmd_pkg::READ_NONE;
      strap_taken         <= 1'b0;
      indicator_style_out <= 1'b0;
      mgmt_rdata_out      <= phy_mmd_pkg::READ_NONE;
      mgmt_rvalid_out     <= 1'b0;
      link_up_time_out    <= phy_mmd_pkg::LINK_UP_RESET[phy_mmd_pkg::LINK_TIME_MSB:phy_mmd_pkg::LINK_TIME_LSB];
    end else if (ce_in) begin
      mmd_addr         <= next_mmd_addr;
      strap_taken      <= 1'b1;
      mgmt_rvalid_out  <= mgmt_rd_in;
      link_up_time_out <= (mmd_wr && sel_link)
                          ? mgmt_wdata_in[phy_mmd_pkg::LINK_TIME_MSB:phy_mmd_pkg::LINK_TIME_LSB]
                          : link_up_q[phy_mmd_pkg::LINK_TIME_MSB:phy_mmd_pkg::LINK_TIME_LSB];
      if (mgmt_rd_in) begin
        mgmt_rdata_out <= next_rdata;
      end
      if (mmd_wr && sel_common) begin
        indicator_style_out <= mgmt_wdata_in[phy_mmd_pkg::OVERRIDE_BIT];
      end else if (!strap_taken) begin
        indicator_style_out <= indicator_style_strap_in;
      end
    end
  end

  // ==========================================================
  // checks
  a_flp_low_reset: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(strap_taken) |-> $past(flp_low_out) == phy_mmd_pkg::FLP_LOW_RESET)
    else $error("flp low word not at reset value");
  a_flp_high_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mmd_wr && sel_flp_hi) |=> flp_high_out == $past(mgmt_wdata_in))
    else $error("flp high word did not take write");
  a_link_ro_bits: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    mmd_wr && sel_link |=> link_up_q[15:9] == 7'h00 && link_up_q[8:0] == $past(mgmt_wdata_in[8:0]))
    else $error("link-up register write handled wrongly");
  a_link_reset_val: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(strap_taken) |-> $past(link_up_q) == phy_mmd_pkg::LINK_UP_RESET
      && link_up_time_out == phy_mmd_pkg::LINK_UP_RESET[phy_mmd_pkg::LINK_TIME_MSB:phy_mmd_pkg::LINK_TIME_LSB])
    else $error("link-up register reset value wrong");
  a_override_reads_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mmd_rd && sel_common) |=> mgmt_rvalid_out && !mgmt_rdata_out[4] && mgmt_rdata_out[3] == $past(indicator_style_out))
    else $error("common control override bit read back nonzero");
  a_style_follows: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mmd_wr && sel_common) |=> indicator_style_out == $past(mgmt_wdata_in[phy_mmd_pkg::OVERRIDE_BIT]))
    else $error("indicator style not updated by override write");
  a_portal_addr_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    addr_set |=> mmd_addr == $past(mgmt_wdata_in))
    else $error("portal register address not loaded");
  a_post_increment: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (ce_in && data_mode && !addr_set) |=> mmd_addr == $past(mmd_addr) +
      (($past(op) == 2'h2 && ($past(mmd_wr) || $past(mmd_rd))) || ($past(op) == 2'h3 && $past(mmd_wr)) ? 16'h0001 : 16'h0000))
    else $error("portal post increment wrong");

  // ==========================================================
  // further checks on reset values, flp low writes, the link-up time field and strap capture
  // reset value of the high word, seen on the strap capture edge
  a_flp_high_reset: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(strap_taken) |-> $past(flp_high_out) == phy_mmd_pkg::FLP_HIGH_RESET)
    else $error("flp high word not at reset value");
  a_flp_low_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mmd_wr && sel_flp_lo) |=> flp_low_out == $past(mgmt_wdata_in))
    else $error("flp low word did not take write");
  // the field output must never drift from the stored register bits
  a_link_time_match: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    link_up_time_out == link_up_q[phy_mmd_pkg::LINK_TIME_MSB:phy_mmd_pkg::LINK_TIME_LSB])
    else $error("link-up time output differs from register");
  // strap level lands unless an override write hits the same edge
  a_style_from_strap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(strap_taken) && !$past(mmd_wr && sel_common) |-> indicator_style_out == $past(indicator_style_strap_in))
    else $error("indicator style not taken from strap");
  a_style_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (strap_taken && !(mmd_wr && sel_common)) |=> $stable(indicator_style_out))
    else $error("indicator style changed without override write");

  // ==========================================================
  // portal read answers and address handling
  a_rvalid_pulse: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ce_in |=> mgmt_rvalid_out == $past(mgmt_rd_in))
    else $error("read valid not one edge after read strobe");
  a_rdata_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !(ce_in && mgmt_rd_in) |=> $stable(mgmt_rdata_out))
    else $error("read data changed without a read");
  a_regmode_read: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rd_data && !data_mode) |=> mgmt_rdata_out == $past(mmd_addr))
    else $error("register mode read did not return the address");
  a_unmapped_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mmd_rd && !(sel_flp_lo || sel_flp_hi || sel_link || sel_common)) |=> mgmt_rdata_out == phy_mmd_pkg::READ_NONE)
    else $error("unmapped indirect register read nonzero");
  a_noinc_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (ce_in && op == phy_mmd_pkg::OP_DATA_NOINC && !wr_ctrl) |=> $stable(mmd_addr))
    else $error("address moved in no-increment mode");
  a_incwr_read_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mmd_rd && !mmd_wr && op == phy_mmd_pkg::OP_DATA_INC_WR) |=> $stable(mmd_addr))
    else $error("address moved on a read in write-increment mode");
  // a low enable must freeze both flp words, the portal address and the read valid
  a_ce_freeze: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !ce_in |=> $stable(flp_low_out) && $stable(flp_high_out) && $stable(mmd_addr) && $stable(mgmt_rvalid_out))
    else $error("state changed while clock enable low");
endmodule

/* phy_mmd_pkg.sv */
// constants for the indirect mmd configuration register bank
package phy_mmd_pkg;
  // ==========================================================
  // portal registers on the management register space
  localparam logic [4:0]  PORTAL_CTRL_REG = 5'h0D;
  localparam logic [4:0]  PORTAL_DATA_REG = 5'h0E;
  localparam int          CTRL_OP_MSB     = 15;
  localparam int          CTRL_OP_LSB     = 14;
  localparam int          CTRL_DEV_MSB    = 4;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [15:0] ALL_WRITABLE    = 16'hFFFF;
  localparam logic [15:0] ADDR_STEP       = 16'h0001;
  localparam logic [15:0] READ_NONE       = 16'h0000;

  // ==========================================================
  // portal operation codes
  localparam logic [1:0]  OP_REGISTER     = 2'h0;
  localparam logic [1:0]  OP_DATA_NOINC   = 2'h1;
  localparam logic [1:0]  OP_DATA_INC_RW  = 2'h2;
  localparam logic [1:0]  OP_DATA_INC_WR  = 2'h3;

  // ==========================================================
  // mmd device and register addresses
  localparam logic [4:0]  DEV_AUTONEG     = 5'h00;
  localparam logic [4:0]  DEV_PMA         = 5'h01;
  localparam logic [4:0]  DEV_COMMON      = 5'h02;
  localparam logic [15:0] FLP_LOW_ADDR    = 16'h0003;
  localparam logic [15:0] FLP_HIGH_ADDR   = 16'h0004;
  localparam logic [15:0] LINK_UP_ADDR    = 16'h005A;
  localparam logic [15:0] COMMON_ADDR     = 16'h0000;

  // ==========================================================
  // reset values, write masks and fields
  localparam logic [15:0] FLP_LOW_RESET   = 16'h4000;
  localparam logic [15:0] FLP_LOW_16MS    = 16'h1A80;
  localparam logic [15:0] FLP_HIGH_RESET  = 16'h0003;
  localparam logic [15:0] FLP_HIGH_16MS   = 16'h0006;
  localparam logic [15:0] LINK_UP_RESET   = 16'h0108; // bits 8:4 = 1_0000, bits 3:1 = 100, bit 0 = 0
  localparam logic [15:0] LINK_UP_WMASK   = 16'h01FF;
  localparam logic [15:0] COMMON_RESET    = 16'h0000;
  localparam logic [15:0] COMMON_WMASK    = 16'hFFE7;
  localparam int          LINK_TIME_MSB   = 3;
  localparam int          LINK_TIME_LSB   = 1;
  localparam int          LINK_RO_MSB     = 15;
  localparam int          LINK_RO_LSB     = 9;
  localparam int          OVERRIDE_BIT    = 4;
  localparam int          STYLE_BIT       = 3;
endpackage

/* tb_phy_mmd_config.sv */
// self-checking bench for the indirect configuration register bank
`timescale 1ns/1ps
module tb_phy_mmd_config;
  typedef struct packed {
    logic [4:0]  dev;
    logic [15:0] rg;
    logic [15:0] wd;
    logic [15:0] rx;
    logic [35:0] ox;
  } row_t;
  logic        mclk_in;
  logic        rst_n_in = 1'b0;
  logic        ce_in    = 1'b1;
  logic        strap    = 1'b1;
  logic [4:0]  addr;
  logic        wr;
  logic        rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic [15:0] low;
  logic [15:0] high;
  logic [2:0]  lut;
  logic        style;
  logic [15:0] v;
  logic        ok;
  int          num_errors   = 0;
  int          total_checks = 0;
  // reserved fields only ever written with their reset values; flp words written in pairs
  row_t rows [7] = '{
    '{5'h00, 16'h0003, 16'h1A80, 16'h1A80, {16'h1A80, 16'h0003, 3'h4, 1'b1}},
    '{5'h00, 16'h0004, 16'h0006, 16'h0006, {16'h1A80, 16'h0006, 3'h4, 1'b1}},
    '{5'h00, 16'h0003, 16'h4000, 16'h4000, {16'h4000, 16'h0006, 3'h4, 1'b1}},
    '{5'h00, 16'h0004, 16'h0003, 16'h0003, {16'h4000, 16'h0003, 3'h4, 1'b1}},
    '{5'h01, 16'h005A, 16'h010E, 16'h010E, {16'h4000, 16'h0003, 3'h7, 1'b1}},
    '{5'h02, 16'h0000, 16'h0000, 16'h0000, {16'h4000, 16'h0003, 3'h7, 1'b0}},
    '{5'h02, 16'h0000, 16'h0010, 16'h0008, {16'h4000, 16'h0003, 3'h7, 1'b1}}
  };

  phy_mmd_config u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .mgmt_addr_in(addr),
    .mgmt_wr_in(wr), .mgmt_rd_in(rd), .mgmt_wdata_in(wdata), .indicator_style_strap_in(strap),
    .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid), .flp_low_out(low), .flp_high_out(high),
    .link_up_time_out(lut), .indicator_style_out(style));
  mgmt_station_model u_host (.mclk_in(mclk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

  // ==========================================================
  // clock and watchdog, generous against about two hundred cycles of traffic
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (5000) @(posedge mclk_in);
    num_errors++;
    results();
  end

  // ==========================================================
  // comparisons and verdict
  task automatic check_read(input logic [15:0] exp);
    total_checks++;
    if ({ok, v} !== {1'b1, exp}) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, {ok, v}, {1'b1, exp});
    end
  endtask
  task automatic check_outs(input logic [35:0] exp);
    #1;
    total_checks++;
    if ({low, high, lut, style} !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, {low, high, lut, style}, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic mmd_read(input logic [4:0] dev, input logic [15:0] rg, input logic [15:0] exp);
    u_host.sel(dev, rg, phy_mmd_pkg::OP_DATA_NOINC);
    u_host.get(phy_mmd_pkg::PORTAL_DATA_REG, v, ok);
    check_read(exp);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    check_outs({16'h4000, 16'h0003, 3'h4, 1'b1});
    mmd_read(5'h00, 16'h0003, 16'h4000);
    mmd_read(5'h00, 16'h0004, 16'h0003);
    mmd_read(5'h01, 16'h005A, 16'h0108);
    mmd_read(5'h02, 16'h0000, 16'h0008);
    for (int i = 0; i < 7; i++) begin
      u_host.sel(rows[i].dev, rows[i].rg, phy_mmd_pkg::OP_DATA_NOINC);
      u_host.put(phy_mmd_pkg::PORTAL_DATA_REG, rows[i].wd);
      u_host.get(phy_mmd_pkg::PORTAL_DATA_REG, v, ok);
      check_read(rows[i].rx);
      check_outs(rows[i].ox);
    end
    // increment on reads and writes mode, driven with two reads
    u_host.sel(5'h00, 16'h0003, phy_mmd_pkg::OP_DATA_INC_RW);
    u_host.get(phy_mmd_pkg::PORTAL_DATA_REG, v, ok);
    check_read(16'h4000);
    u_host.get(phy_mmd_pkg::PORTAL_DATA_REG, v, ok);
    check_read(16'h0003);
    // increment on writes only: reads stay put, writes walk low then high
    u_host.sel(5'h00, 16'h0003, phy_mmd_pkg::OP_DATA_INC_WR);
    u_host.get(phy_mmd_pkg::PORTAL_DATA_REG, v, ok);
    check_read(16'h4000);
    u_host.get(phy_mmd_pkg::PORTAL_DATA_REG, v, ok);
    check_read(16'h4000);
    u_host.put(phy_mmd_pkg::PORTAL_DATA_REG, 16'h1A80);
    u_host.put(phy_mmd_pkg::PORTAL_DATA_REG, 16'h0006);
    check_outs({16'h1A80, 16'h0006, 3'h7, 1'b1});
    // register mode reads back the address
    u_host.put(phy_mmd_pkg::PORTAL_CTRL_REG, 16'h0000);
    u_host.put(phy_mmd_pkg::PORTAL_DATA_REG, 16'h0004);
    u_host.get(phy_mmd_pkg::PORTAL_DATA_REG, v, ok);
    check_read(16'h0004);
    // frozen clock enable ignores a write
    u_host.sel(5'h00, 16'h0003, phy_mmd_pkg::OP_DATA_NOINC);
    @(posedge mclk_in) ce_in <= 1'b0;
    u_host.put(phy_mmd_pkg::PORTAL_DATA_REG, 16'h4000);
    ce_in <= 1'b1;
    check_outs({16'h1A80, 16'h0006, 3'h7, 1'b1});
    mmd_read(5'h02, 16'h0005, 16'h0000);
    // second reset with the strap low
    @(posedge mclk_in) rst_n_in <= 1'b0;
    strap <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    check_outs({16'h4000, 16'h0003, 3'h4, 1'b0});
    mmd_read(5'h02, 16'h0000, 16'h0000);
    results();
  end
endmodule
